//--- rtl/itq_map.vh
// Constants for the ten-bit two-wire slave with enable quirks
`ifndef ITQ_MAP_VH
`define ITQ_MAP_VH
`define ITQ_HDR_TEN     5'h1e
`define ITQ_QUIRK_ADDR  10'h102
`define ITQ_QUIRK_LOW   8'h01
`define ITQ_GLITCH_CYC  8'h04
`define ITQ_FIFO_DEPTH  4
`define ITQ_FIFO_WIDTH  9
`endif

//--- rtl/itq_fifo.v
// Small valid/ready FIFO for received bytes
`timescale 1ns/10ps
module itq_fifo #(
   parameter WIDTH = 9,
   parameter DEPTH = 4,
   parameter AW    = 2
) (
   input  wire             clk,      // Clock
   input  wire             rst,      // Sync reset
   input  wire [WIDTH-1:0] in_data,  // Write data
   input  wire             in_valid, // Write request
   output wire             in_ready, // Not full
   output wire [WIDTH-1:0] out_data, // Head word
   output wire             out_valid,// Not empty
   input  wire             out_ready // Consumer takes head
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0]    wp_reg;
   reg [AW-1:0]    rp_reg;
   reg [AW:0]      cnt_reg;
   wire            wr;
   wire            rd;
   assign in_ready  = (cnt_reg != DEPTH);
   assign out_valid = (cnt_reg != 0);
   assign out_data  = mem[rp_reg];
   assign wr = in_valid & in_ready;
   assign rd = out_valid & out_ready;
   always @(posedge clk) begin
      if (wr) begin
         mem[wp_reg] <= in_data;
      end
      if (rst) begin
         wp_reg  <= {AW{1'b0}};
         rp_reg  <= {AW{1'b0}};
         cnt_reg <= {(AW+1){1'b0}};
      end else begin
         if (wr) begin
            wp_reg <= wp_reg + 1'b1;
         end
         if (rd) begin
            rp_reg <= rp_reg + 1'b1;
         end
         if (wr & ~rd) begin
            cnt_reg <= cnt_reg + 1'b1;
         end else if (rd & ~wr) begin
            cnt_reg <= cnt_reg - 1'b1;
         end
      end
   end
endmodule // itq_fifo

//--- rtl/itq_slave.v
// Ten-bit two-wire slave with enable glitch and address quirks
`timescale 1ns/10ps
`include "itq_map.vh"
module itq_slave (
   input  wire       clk,                // 200 MHz clock
   input  wire       rst,                // Sync reset, active high
   input  wire       module_enable_bit,  // Module enable
   input  wire       pin_owner_active,   // Higher-priority pin owner holds pins
   input  wire [9:0] own_addr,           // Ten-bit slave address
   input  wire       scl_in,             // Bus clock line level
   output reg        scl_out,            // Clock drive value (always 0)
   output reg        scl_oe,             // Clock pull-down enable
   input  wire       sda_in,             // Bus data line level
   output reg        sda_out,            // Data drive value (always 0)
   output reg        sda_oe,             // Data pull-down enable
   input  wire [7:0] tx_data,            // Byte to send on reads
   output reg  [7:0] receive_holding_register, // Received byte
   output reg        receive_full_flag,  // Byte waiting
   output reg        rx_is_data,         // Held byte is data, not address
   input  wire       rx_read,            // Pulse: software read the byte
   output reg        start_seen,         // Start detected status
   output reg        stop_seen,          // Stop detected status
   output reg        tx_mode,            // Transmitting for a read
   output reg        overflow            // Byte lost, FIFO full
);
   localparam ST_IDLE = 3'h0, ST_HI = 3'h1, ST_LO = 3'h2, ST_DATA = 3'h3;
   localparam ST_ACK = 3'h4, ST_TX = 3'h5, ST_TACK = 3'h6, ST_WAIT = 3'h7;

   // Reserved low-byte pattern check with exceptions
   function suppress;
      input [9:0] a;
      begin
         // Quirk address still loads, though its low byte looks reserved
         suppress = ((a[7:4] == 4'h0) || (a[7:4] == 4'hf)) &&
                    !((a[7:4] == 4'hf) && (a[3:1] == {1'b0, a[9:8]})) &&
                    (a != `ITQ_QUIRK_ADDR);
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   reg [1:0] scl_s_reg, sda_s_reg;
   reg       scl_d_reg, sda_d_reg;
   reg       en_d_reg;
   reg [7:0] glitch_reg;
   reg [2:0] st_reg;
   reg [3:0] bit_reg;
   reg [7:0] sh_reg;
   reg [7:0] txs_reg;
   reg       hdr_ok_reg, matched_reg, ack_now_reg, rd_reg, nack_reg;
   wire scl = scl_s_reg[1];
   wire sda = sda_s_reg[1];
   wire scl_rise = scl & ~scl_d_reg;
   wire scl_fall = ~scl & scl_d_reg;
   wire start_c = scl & scl_d_reg & sda_d_reg & ~sda;
   wire stop_c  = scl & scl_d_reg & ~sda_d_reg & sda;
   wire en_rise = module_enable_bit & ~en_d_reg;

   reg        f_valid;
   reg  [8:0] f_data;
   wire       f_ready;
   wire [8:0] h_data;
   wire       h_valid;
   wire       h_take = h_valid & (~receive_full_flag | rx_read);

   itq_fifo #(.WIDTH(`ITQ_FIFO_WIDTH), .DEPTH(`ITQ_FIFO_DEPTH), .AW(2)) i_itq_fifo (
      .clk       (clk),
      .rst       (rst),
      .in_data   (f_data),
      .in_valid  (f_valid),
      .in_ready  (f_ready),
      .out_data  (h_data),
      .out_valid (h_valid),
      .out_ready (h_take)
   );

   ////////////////////////////////////////////////////////////////////////
   always @(posedge clk) begin
      if (rst) begin
         scl_s_reg <= 2'h3;
         sda_s_reg <= 2'h3;
         scl_d_reg <= 1'b1;
         sda_d_reg <= 1'b1;
         en_d_reg  <= 1'b0;
      end else begin
         scl_s_reg <= {scl_s_reg[0], scl_in};
         sda_s_reg <= {sda_s_reg[0], sda_in};
         scl_d_reg <= scl;
         sda_d_reg <= sda;
         en_d_reg  <= module_enable_bit;
      end
   end

   always @(posedge clk) begin
      f_valid <= 1'b0;
      f_data  <= 9'h000;
      if (rst) begin
         st_reg <= ST_IDLE;
         bit_reg <= 4'h0;
         sh_reg <= 8'h00;
         txs_reg <= 8'h00;
         hdr_ok_reg <= 1'b0;
         matched_reg <= 1'b0;
         ack_now_reg <= 1'b0;
         rd_reg <= 1'b0;
         nack_reg <= 1'b0;
         glitch_reg <= 8'h00;
         start_seen <= 1'b0;
         stop_seen <= 1'b0;
         tx_mode <= 1'b0;
         overflow <= 1'b0;
         sda_oe <= 1'b0;
         scl_oe <= 1'b0;
         sda_out <= 1'b0;
         scl_out <= 1'b0;
      end else begin
         sda_out <= 1'b0;
         scl_out <= 1'b0;
         if (en_rise) begin
            start_seen <= 1'b1;
            stop_seen  <= 1'b0;
            // Masked when another peripheral owns the pins
            glitch_reg <= pin_owner_active ? 8'h00 : `ITQ_GLITCH_CYC;
         end else if (glitch_reg != 8'h00) begin
            glitch_reg <= glitch_reg - 8'h01;
         end
         // Pull both lines low briefly on enable
         scl_oe <= (en_rise & ~pin_owner_active) | (glitch_reg > 8'h01);
         if (overflow & rx_read) begin
            overflow <= 1'b0;
         end
         if (!module_enable_bit) begin
            st_reg <= ST_IDLE;
            sda_oe <= 1'b0;
            tx_mode <= 1'b0;
         end else if (start_c) begin
            start_seen <= 1'b1;
            stop_seen <= 1'b0;
            st_reg <= ST_HI;
            bit_reg <= 4'h0;
            sda_oe <= 1'b0;
            tx_mode <= 1'b0;
         end else if (stop_c) begin
            start_seen <= 1'b0;
            stop_seen <= 1'b1;
            st_reg <= ST_IDLE;
            sda_oe <= 1'b0;
            tx_mode <= 1'b0;
            matched_reg <= 1'b0;
            rd_reg <= 1'b0;
         end else begin
            case (st_reg)
               ST_HI, ST_LO, ST_DATA: begin
                  if (scl_rise && bit_reg < 4'h8) begin
                     sh_reg <= {sh_reg[6:0], sda};
                     bit_reg <= bit_reg + 4'h1;
                  end else if (scl_fall && bit_reg == 4'h8) begin
                     ack_now_reg <= 1'b0;
                     if (st_reg == ST_HI) begin
                        // Only top bits compared: shared bits ack alike
                        hdr_ok_reg <= (sh_reg[7:3] == `ITQ_HDR_TEN) &&
                                      (sh_reg[2:1] == own_addr[9:8]);
                        if ((sh_reg[7:3] == `ITQ_HDR_TEN) &&
                            (sh_reg[2:1] == own_addr[9:8])) begin
                           ack_now_reg <= 1'b1;
                           sda_oe <= 1'b1;
                           rd_reg <= sh_reg[0] & matched_reg;
                           // Match survives a repeated start only for a read header
                           if (!sh_reg[0]) begin
                              matched_reg <= 1'b0;
                           end
                        end else begin
                           matched_reg <= 1'b0;
                        end
                     end else if (st_reg == ST_LO && sh_reg == own_addr[7:0]) begin
                        ack_now_reg <= 1'b1;
                        sda_oe <= 1'b1;
                        matched_reg <= 1'b1;
                        if (!suppress(own_addr)) begin
                           f_valid <= f_ready;
                           f_data <= {1'b0, (own_addr == `ITQ_QUIRK_ADDR) ?
                                      `ITQ_QUIRK_LOW : sh_reg};
                           overflow <= overflow | ~f_ready;
                        end
                     end else if (st_reg == ST_DATA && matched_reg) begin
                        ack_now_reg <= 1'b1;
                        sda_oe <= 1'b1;
                        f_valid <= f_ready;
                        f_data <= {1'b1, sh_reg};
                        overflow <= overflow | ~f_ready;
                     end
                     st_reg <= ST_ACK;
                  end
               end
               ST_ACK: begin
                  if (scl_fall) begin
                     sda_oe <= 1'b0;
                     bit_reg <= 4'h0;
                     if (!ack_now_reg) begin
                        st_reg <= ST_WAIT;
                     end else if (rd_reg) begin
                        // Open-drain drive: a second sender ANDs on the line
                        tx_mode <= 1'b1;
                        txs_reg <= {tx_data[6:0], 1'b0};
                        sda_oe <= ~tx_data[7];
                        bit_reg <= 4'h1;
                        st_reg <= ST_TX;
                     end else if (hdr_ok_reg && !matched_reg) begin
                        hdr_ok_reg <= 1'b0;
                        st_reg <= ST_LO;
                     end else begin
                        st_reg <= ST_DATA;
                     end
                  end
               end
               ST_TX: begin
                  if (scl_fall) begin
                     if (bit_reg == 4'h8) begin
                        sda_oe <= 1'b0;
                        st_reg <= ST_TACK;
                     end else begin
                        sda_oe <= ~txs_reg[7];
                        txs_reg <= {txs_reg[6:0], 1'b0};
                        bit_reg <= bit_reg + 4'h1;
                     end
                  end
               end
               ST_TACK: begin
                  if (scl_rise) begin
                     nack_reg <= sda;
                  end else if (scl_fall) begin
                     if (nack_reg) begin
                        tx_mode <= 1'b0;
                        st_reg <= ST_WAIT;
                     end else begin
                        txs_reg <= {tx_data[6:0], 1'b0};
                        sda_oe <= ~tx_data[7];
                        bit_reg <= 4'h1;
                        st_reg <= ST_TX;
                     end
                  end
               end
               default: begin
                  sda_oe <= 1'b0;
               end
            endcase
         end
         // Enable glitch overrides data drive too
         if (en_rise & ~pin_owner_active) begin
            sda_oe <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Holding register refills from FIFO; set beats software clear
   always @(posedge clk) begin
      if (rst) begin
         receive_holding_register <= 8'h00;
         receive_full_flag <= 1'b0;
         rx_is_data <= 1'b0;
      end else if (h_take) begin
         receive_holding_register <= h_data[7:0];
         rx_is_data <= h_data[8];
         receive_full_flag <= 1'b1;
      end else if (rx_read) begin
         receive_full_flag <= 1'b0;
      end
   end
endmodule // itq_slave

//--- tb/itq_slave_monitor.sv
// Checker for the ten-bit two-wire slave, bound to its ports
`timescale 1ns/10ps
module itq_slave_monitor (
   input wire       clk,                      // Clock
   input wire       rst,                      // Reset
   input wire       module_enable_bit,        // Enable
   input wire       pin_owner_active,         // Pin owner
   input wire [9:0] own_addr,                 // Address
   input wire       scl_out,                  // Clock value
   input wire       scl_oe,                   // Clock pull
   input wire       sda_out,                  // Data value
   input wire       sda_oe,                   // Data pull
   input wire [7:0] receive_holding_register, // Held byte
   input wire       receive_full_flag,        // Full
   input wire       rx_is_data,               // Data byte
   input wire       rx_read,                  // Read pulse
   input wire       start_seen,               // Start
   input wire       stop_seen,                // Stop
   input wire       tx_mode,                  // Transmit
   input wire       overflow                  // Lost byte
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   function automatic bit low_ok(input [9:0] a);
      return a == 10'h102 ||
             !(a[7:4] == 4'h0 || (a[7:4] == 4'hf && a[3:1] != {1'b0, a[9:8]}));
   endfunction
   ////////////////////////////////////////////////////////////////////////////
   property p_en_start;
      $rose(module_enable_bit) |-> ##[1:3] (start_seen && !stop_seen);
   endproperty
   a_en_start: assert property (p_en_start) else $error("start status missing");
   property p_en_glitch;
      $rose(module_enable_bit) && !pin_owner_active |-> ##[1:4] (scl_oe && sda_oe);
   endproperty
   a_en_glitch: assert property (p_en_glitch) else $error("no enable glitch");
   property p_en_masked;
      $rose(module_enable_bit) && pin_owner_active |-> (!scl_oe && !sda_oe) [*6];
   endproperty
   a_en_masked: assert property (p_en_masked) else $error("glitch not masked");
   property p_off_quiet;
      !module_enable_bit && !$past(module_enable_bit) |-> !scl_oe && !sda_oe;
   endproperty
   a_off_quiet: assert property (p_off_quiet) else $error("drive while off");
   property p_open_drain;
      !scl_out && !sda_out;
   endproperty
   a_open_drain: assert property (p_open_drain) else $error("line driven high");
   property p_full_clear;
      $fell(receive_full_flag) |-> $past(rx_read) || $past(rx_read, 2);
   endproperty
   a_full_clear: assert property (p_full_clear) else $error("full lost unread");
   property p_no_reserved;
      $rose(receive_full_flag) && !rx_is_data |-> low_ok(own_addr);
   endproperty
   a_no_reserved: assert property (p_no_reserved) else $error("reserved loaded");
   property p_low_value;
      $rose(receive_full_flag) && !rx_is_data && own_addr != 10'h102
         |-> ##[0:2] (receive_holding_register == own_addr[7:0]);
   endproperty
   a_low_value: assert property (p_low_value) else $error("low byte wrong");
   property p_quirk;
      $rose(receive_full_flag) && !rx_is_data && own_addr == 10'h102
         |-> ##[0:2] (receive_holding_register == 8'h01);
   endproperty
   a_quirk: assert property (p_quirk) else $error("quirk byte wrong");
   c_glitch: cover property ($rose(module_enable_bit) && !pin_owner_active);
   c_full: cover property ($rose(receive_full_flag));
   c_tx: cover property ($rose(tx_mode));
   c_ovf: cover property ($rose(overflow));
endmodule // itq_slave_monitor

bind itq_slave itq_slave_monitor i_itq_slave_monitor (
   .clk(clk), .rst(rst), .module_enable_bit(module_enable_bit),
   .pin_owner_active(pin_owner_active), .own_addr(own_addr), .scl_out(scl_out),
   .scl_oe(scl_oe), .sda_out(sda_out), .sda_oe(sda_oe),
   .receive_holding_register(receive_holding_register),
   .receive_full_flag(receive_full_flag), .rx_is_data(rx_is_data), .rx_read(rx_read),
   .start_seen(start_seen), .stop_seen(stop_seen), .tx_mode(tx_mode), .overflow(overflow)
);

//--- tb/itq_partner.sv
// Bus master model driving the open-drain lines
`timescale 1ns/10ps
module itq_partner (
   output logic scl_low, // Pull clock low
   output logic sda_low, // Pull data low
   input  wire  sda      // Data line level
);
   // Idle and released until the bench starts a frame
   initial begin
      scl_low = 1'b0;
      sda_low = 1'b0;
   end
   // Also serves as repeated start after an ack bit
   task do_start;
      sda_low = 1'b0;
      #16 scl_low = 1'b0;
      #16 sda_low = 1'b1;
      #16 scl_low = 1'b1;
      #16;
   endtask
   task do_bit(input logic b, output logic s);
      sda_low = !b;
      #16 scl_low = 1'b0;
      #16 s = sda;
      #16 scl_low = 1'b1;
      #16;
   endtask
   task do_byte(input logic [7:0] d, input logic mack, output logic [7:0] r, output logic k);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         do_bit(d[i], s);
         r[i] = s;
      end
      do_bit(mack, k);
   endtask
   // Clock then stands still high between frames
   task do_stop;
      sda_low = 1'b1;
      #16 scl_low = 1'b0;
      #16 sda_low = 1'b0;
      #32;
   endtask
endmodule // itq_partner

//--- tb/itq_slave_bench.sv
// Self-checking bench for the ten-bit two-wire slave
`timescale 1ns/10ps
module itq_slave_bench;
   logic       clk = 1'b0, rst = 1'b1, module_enable_bit = 1'b0;
   logic       pin_owner_active = 1'b0, rx_read = 1'b0, m_scl, m_sda;
   logic [9:0] own_addr = 10'h2a5;
   logic [7:0] tx_data = 8'h5c;
   wire        scl_in, sda_in, scl_out, scl_oe, sda_out, sda_oe, receive_full_flag;
   wire        rx_is_data, start_seen, stop_seen, tx_mode, overflow;
   wire  [7:0] receive_holding_register;
   int         bad_count = 0, check_count = 0;
   // Wired-AND with pull-ups
   assign scl_in = !(scl_oe || m_scl);
   assign sda_in = !(sda_oe || m_sda);
   always #2.5 clk = !clk;
   itq_slave i_itq_slave (
      .clk(clk), .rst(rst), .module_enable_bit(module_enable_bit),
      .pin_owner_active(pin_owner_active), .own_addr(own_addr), .scl_in(scl_in),
      .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
      .tx_data(tx_data), .receive_holding_register(receive_holding_register),
      .receive_full_flag(receive_full_flag), .rx_is_data(rx_is_data), .rx_read(rx_read),
      .start_seen(start_seen), .stop_seen(stop_seen), .tx_mode(tx_mode), .overflow(overflow)
   );
   itq_partner i_itq_partner (.scl_low(m_scl), .sda_low(m_sda), .sda(sda_in));
   ////////////////////////////////////////////////////////////////////////////
   task chk(input string what, input logic [9:0] seen, input logic [9:0] exp);
      check_count++;
      if (seen !== exp) begin
         bad_count++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task give_verdict;
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   task pop;
      @(posedge clk) rx_read <= 1'b1;
      @(posedge clk) rx_read <= 1'b0;
      cyc(4);
   endtask
   task drain;
      repeat (8) if (receive_full_flag === 1'b1) pop;
   endtask
   task t_enable(input logic own);
      logic g;
      g = 1'b0;
      @(posedge clk) module_enable_bit <= 1'b0;
      @(posedge clk) pin_owner_active <= own;
      cyc(4);
      @(posedge clk) module_enable_bit <= 1'b1;
      repeat (12) begin
         @(posedge clk);
         g = g | (scl_oe & sda_oe);
      end
      chk("glitch", g, !own);
      chk("start", start_seen, 1'b1);
      chk("stop", stop_seen, 1'b0);
      @(posedge clk) pin_owner_active <= 1'b0;
      cyc(30);
   endtask
   task t_addr(input logic [9:0] a, input logic load, input logic [7:0] v);
      logic [7:0] r;
      logic       k;
      @(posedge clk) own_addr <= a;
      i_itq_partner.do_start;
      i_itq_partner.do_byte({5'h1e, a[9:8], 1'b0}, 1'b1, r, k);
      chk("hdr ack", k, 1'b0);
      i_itq_partner.do_byte(a[7:0], 1'b1, r, k);
      chk("low ack", k, 1'b0);
      cyc(10);
      chk("full", receive_full_flag, load);
      if (load) chk("held", receive_holding_register, v);
      drain;
      i_itq_partner.do_stop;
      cyc(10);
   endtask
   task t_read;
      logic [7:0] r;
      logic       k;
      @(posedge clk) own_addr <= 10'h2a5;
      i_itq_partner.do_start;
      i_itq_partner.do_byte(8'hf4, 1'b1, r, k);
      i_itq_partner.do_byte(8'ha5, 1'b1, r, k);
      i_itq_partner.do_start;
      i_itq_partner.do_byte(8'hf5, 1'b1, r, k);
      chk("rd ack", k, 1'b0);
      chk("tx mode", tx_mode, 1'b1);
      // Master sends its own stream at once, as the sharing node does
      i_itq_partner.do_byte(8'hf0, 1'b1, r, k);
      chk("and data", r, tx_data & 8'hf0);
      i_itq_partner.do_stop;
      cyc(10);
      chk("stop seen", {start_seen, stop_seen}, 2'b01);
      drain;
   endtask
   task t_flood;
      logic [7:0] r;
      logic       k;
      i_itq_partner.do_start;
      i_itq_partner.do_byte(8'hf4, 1'b1, r, k);
      i_itq_partner.do_byte(8'ha5, 1'b1, r, k);
      repeat (6) i_itq_partner.do_byte(8'h3c, 1'b1, r, k);
      i_itq_partner.do_stop;
      cyc(10);
      chk("overflow", overflow, 1'b1);
      chk("first", receive_holding_register, 8'ha5);
      chk("addr kind", rx_is_data, 1'b0);
      pop;
      chk("data", receive_holding_register, 8'h3c);
      chk("data kind", rx_is_data, 1'b1);
      drain;
      chk("empty", receive_full_flag, 1'b0);
      chk("ovf clear", overflow, 1'b0);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      cyc(2);
      rst <= 1'b0;
      cyc(2);
      chk("reset", {scl_oe, sda_oe, receive_full_flag, start_seen, tx_mode, overflow}, 10'h0);
      t_enable(1'b1);
      t_enable(1'b0);
      t_addr(10'h2a5, 1'b1, 8'ha5);
      t_addr(10'h305, 1'b0, 8'h00);
      t_addr(10'h1f8, 1'b0, 8'h00);
      t_addr(10'h0f0, 1'b1, 8'hf0);
      t_addr(10'h1f2, 1'b1, 8'hf2);
      t_addr(10'h2f5, 1'b1, 8'hf5);
      t_addr(10'h3f6, 1'b1, 8'hf6);
      t_addr(10'h102, 1'b1, 8'h01);
      t_read;
      t_flood;
      give_verdict;
   end
   // Whole run needs about a fifth of this span
   initial begin
      #100000;
      bad_count++;
      give_verdict;
   end
endmodule // itq_slave_bench
